// >>> hw/iosag_map.vh
// Purpose: constants for the I/O-space indirect address generator
// Assumes: included by iosag_top.v only
// Notes: operand codes are local encodings from the decoder
//
// What this block does
// [RULE_01] Aux minus index-one: address is [start+]pointer, then pointer minus index-one.
// [RULE_02] Post-modify forms present the unmodified pointer; update lands afterwards.
// [RULE_03] Aux indexed by index-one: address [start+]pointer+index; pointer unchanged.
// [RULE_04] Short constant 1..7 added to [start+]pointer; pointer unchanged.
// [RULE_05] Plain coefficient operand: address [coef start+]pointer; pointer unchanged.
// [RULE_06] Coefficient post-increment: address from current pointer, then pointer plus one.
// [RULE_07] Coefficient post-decrement: address from current pointer, then pointer minus one.
// [RULE_08] Extended coefficient pointer is 23 bits: 7 page bits over 16 low bits.
// [RULE_09] Long-offset operands, base or pre-add, aux or coef, are illegal for I/O.
// [RULE_10] Memory delay and multiply-accumulate-with-delay may not access I/O space.
// [RULE_11] Any illegal I/O access raises the bus-error interrupt request.
// [RULE_12] Buffer start is added only when the pointer's circular-select bit is set.
// [RULE_13] Aux pointer n uses status bit n; coefficient pointer uses status bit 8.
// [RULE_14] Pointer modification touches the low 16 bits only; page bits stay.
// [RULE_15] Address goes to I/O space only with the I/O qualifier, else data space.
`ifndef IOSAG_MAP_VH
`define IOSAG_MAP_VH
`define IOSAG_OP_AUX_MINUS_IDX  4'h0
`define IOSAG_OP_AUX_INDEXED    4'h1
`define IOSAG_OP_AUX_SHORT      4'h2
`define IOSAG_OP_COEF           4'h3
`define IOSAG_OP_COEF_INC       4'h4
`define IOSAG_OP_COEF_DEC       4'h5
`define IOSAG_OP_AUX_LONG       4'h6
`define IOSAG_OP_AUX_PRE_LONG   4'h7
`define IOSAG_OP_COEF_LONG      4'h8
`define IOSAG_OP_COEF_PRE_LONG  4'h9
`define IOSAG_COEF_CIRC_BIT     8
`define IOSAG_PAGE_W            7
`define IOSAG_LOW_W             16
`define IOSAG_COEF_STEP         16'h0001
`define IOSAG_PTR_RESET         23'h000000
`endif

// >>> hw/iosag_top.v
// Purpose: address generation for indirect operands aimed at I/O space
// Assumes: decoder presents one operand per cycle with op_valid; ref_clk 100 MHz
// Notes: address outputs registered, one cycle after op_valid; pointer file
//        update is presented as a write-back strobe in the same cycle
`timescale 1ns/1ps
`include "iosag_map.vh"
module iosag_top #(
  parameter NUM_AUX = 8
) (
  // Clock and reset
  input  wire        ref_clk,
  input  wire        reset_n,
  // Decoded operand
  input  wire        op_valid,
  input  wire [3:0]  op_kind,
  input  wire [2:0]  aux_sel,
  input  wire [2:0]  short_offset_const,
  input  wire        io_qualifier,
  input  wire        delay_instr,
  input  wire        mac_with_delay_op,
  // Pointer file values
  input  wire [22:0] ext_aux_pointer,
  input  wire [15:0] index_reg_one,
  input  wire [15:0] aux_buffer_start,
  input  wire [15:0] coef_buffer_start,
  input  wire [15:0] status_reg_two,
  // Coefficient pointer load from the CPU
  input  wire        coef_load,
  input  wire [22:0] coef_load_value,
  // Aux write-back to the pointer file
  output reg         aux_wb_en,
  output reg  [22:0] aux_wb_value,
  // Coefficient pointer state
  output wire [22:0] ext_coef_pointer,
  // Address outputs
  output reg         io_req,
  output reg         data_req,
  output reg  [22:0] addr_out,
  // Interrupt request
  output reg         bus_error_irq
);

  // Operand classes, one flag per addressing form; the base and pre-add long-offset forms share one
  reg         op_aux_minus;
  reg         op_aux_index;
  reg         op_aux_short;
  reg         op_coef_plain;
  reg         op_coef_inc;
  reg         op_coef_dec;
  reg         op_long_aux;
  reg         op_long_coef;

  // Pointer fields, page over low part
  reg  [22:0] coef_ptr_reg;                                   // [RULE_08]
  reg  [22:0] coef_ptr_next;
  wire [6:0]  coef_page_bits   = coef_ptr_reg[22:16];
  wire [15:0] coef_pointer_low = coef_ptr_reg[15:0];
  wire [6:0]  aux_page         = ext_aux_pointer[22:16];
  wire [15:0] aux_pointer_low  = ext_aux_pointer[15:0];

  // Circular select per pointer
  wire [NUM_AUX-1:0] aux_circ_select;
  wire               coef_circ_select;
  wire               aux_circ_on;

  // Address terms
  wire [15:0] aux_start_term;
  wire [15:0] coef_start_term;
  wire [15:0] aux_base;
  wire [15:0] coef_base;
  reg  [15:0] aux_offset;
  reg  [15:0] low_addr;
  reg  [6:0]  page_sel;

  // Legality
  wire        uses_coef;
  wire        long_form;
  wire        delay_form;
  wire        illegal;

  // Pointer updates
  reg  [15:0] coef_low_step;
  wire [15:0] aux_low_new;
  wire        aux_wb_now;

  // Decode the operand code into one flag per form. Unused codes select no
  // form at all, so they fall through to the plain aux base address.
  always @* begin
    op_aux_minus  = 1'h0;
    op_aux_index  = 1'h0;
    op_aux_short  = 1'h0;
    op_coef_plain = 1'h0;
    op_coef_inc   = 1'h0;
    op_coef_dec   = 1'h0;
    op_long_aux   = 1'h0;
    op_long_coef  = 1'h0;
    case (op_kind)
      `IOSAG_OP_AUX_MINUS_IDX: op_aux_minus  = 1'h1;
      `IOSAG_OP_AUX_INDEXED:   op_aux_index  = 1'h1;
      `IOSAG_OP_AUX_SHORT:     op_aux_short  = 1'h1;
      `IOSAG_OP_COEF:          op_coef_plain = 1'h1;
      `IOSAG_OP_COEF_INC:      op_coef_inc   = 1'h1;
      `IOSAG_OP_COEF_DEC:      op_coef_dec   = 1'h1;
      `IOSAG_OP_AUX_LONG,
      `IOSAG_OP_AUX_PRE_LONG:  op_long_aux   = 1'h1;          // [RULE_09]
      `IOSAG_OP_COEF_LONG,
      `IOSAG_OP_COEF_PRE_LONG: op_long_coef  = 1'h1;          // [RULE_09]
      default:                 op_aux_minus  = 1'h0;
    endcase
  end

  assign uses_coef = op_coef_plain | op_coef_inc | op_coef_dec | op_long_coef;
  assign long_form = op_long_aux | op_long_coef;

  // Status bit n selects circular mode for aux pointer n
  genvar gi;
  generate
    for (gi = 0; gi < NUM_AUX; gi = gi + 1) begin : g_circ
      assign aux_circ_select[gi] = status_reg_two[gi];        // [RULE_13]
    end
  endgenerate
  assign coef_circ_select = status_reg_two[`IOSAG_COEF_CIRC_BIT]; // [RULE_13]
  assign aux_circ_on      = aux_circ_select[aux_sel];

  // Start value joins the sum only under circular select. The sum wraps at
  // 64K, so a carry never reaches the page field; crossing pages needs a
  // new page value from software.
  assign aux_start_term  = aux_circ_on ? aux_buffer_start : 16'h0000;      // [RULE_12]
  assign coef_start_term = coef_circ_select ? coef_buffer_start : 16'h0000; // [RULE_12]
  assign aux_base        = aux_start_term + aux_pointer_low;
  assign coef_base       = coef_start_term + coef_pointer_low;

  // Offset on top of the aux base; zero for the post-modify form
  always @* begin
    aux_offset = 16'h0000;
    if (op_aux_index)
      aux_offset = index_reg_one;                             // [RULE_03]
    else if (op_aux_short)
      aux_offset = {13'h0000, short_offset_const};            // [RULE_04]
  end

  // Post-modify forms use the pointer as it stands now; the update lands in
  // the pointer register or the write-back only at the next edge
  always @* begin
    if (uses_coef) begin
      low_addr = coef_base;                                   // [RULE_05] [RULE_02]
      page_sel = coef_page_bits;
    end else begin
      low_addr = aux_base + aux_offset;                       // [RULE_01] [RULE_03]
      page_sel = aux_page;
    end
  end

  // Long-offset and delay forms are refused for I/O space only; without
  // the qualifier they are ordinary data-space accesses
  assign delay_form = delay_instr | mac_with_delay_op;        // [RULE_10]
  assign illegal    = io_qualifier & (long_form | delay_form); // [RULE_09] [RULE_10]

  // Coefficient pointer steps on the low part only, page held
  always @* begin
    coef_low_step = coef_pointer_low;
    if (op_valid && op_coef_inc)
      coef_low_step = coef_pointer_low + `IOSAG_COEF_STEP;   // [RULE_06]
    else if (op_valid && op_coef_dec)
      coef_low_step = coef_pointer_low - `IOSAG_COEF_STEP;   // [RULE_07]
  end

  // A load from the CPU wins over the step. The step still applies under an
  // illegal delay form, since the pointer side keeps no record of refusals.
  always @* begin
    coef_ptr_next = {coef_page_bits, coef_low_step};         // [RULE_14]
    if (coef_load)
      coef_ptr_next = coef_load_value;
  end

  // Aux post-decrement by index-one; page bits travel unchanged
  assign aux_low_new = aux_pointer_low - index_reg_one;      // [RULE_01]
  assign aux_wb_now  = op_valid & op_aux_minus & ~illegal;

  assign ext_coef_pointer = coef_ptr_reg;

  // Coefficient pointer register
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      coef_ptr_reg <= `IOSAG_PTR_RESET;
    end else begin
      coef_ptr_reg <= coef_ptr_next;                         // [RULE_02]
    end
  end

  // Space routing and the error pulse; an illegal access gets no request
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      io_req        <= 1'h0;
      data_req      <= 1'h0;
      bus_error_irq <= 1'h0;
    end else begin
      io_req        <= op_valid & io_qualifier & ~illegal;   // [RULE_15]
      data_req      <= op_valid & ~io_qualifier;             // [RULE_15]
      bus_error_irq <= op_valid & illegal;                   // [RULE_11]
    end
  end

  // Address register, refreshed every cycle whether or not a request runs
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      addr_out <= `IOSAG_PTR_RESET;
    end else begin
      addr_out <= {page_sel, low_addr};
    end
  end

  // Write-back to the pointer file, suppressed together with the request
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      aux_wb_en    <= 1'h0;
      aux_wb_value <= `IOSAG_PTR_RESET;
    end else begin
      aux_wb_en    <= aux_wb_now;                            // [RULE_01]
      aux_wb_value <= {aux_page, aux_low_new};               // [RULE_14]
    end
  end

endmodule

// >>> testbench/iosag_monitor.sv
// Purpose: port checks for iosag_top
// Assumes: single ref_clk domain
// Notes: bound at the foot of this file
`timescale 1ns/1ps
module iosag_monitor(
  input wire        ref_clk, reset_n, op_valid, io_qualifier, delay_instr, mac_with_delay_op,
  input wire        coef_load, aux_wb_en, io_req, data_req, bus_error_irq,
  input wire [3:0]  op_kind,
  input wire [15:0] index_reg_one, coef_buffer_start, status_reg_two,
  input wire [22:0] ext_aux_pointer, aux_wb_value, ext_coef_pointer, addr_out);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  wire        lng = op_kind >= 4'h6 && op_kind <= 4'h9;
  wire        bad = io_qualifier & (lng | delay_instr | mac_with_delay_op);
  wire [22:0] cp = ext_coef_pointer;
  wire [15:0] dn = ext_aux_pointer[15:0] - index_reg_one;
  wire [15:0] ca = (status_reg_two[8] ? coef_buffer_start : 16'h0) + cp[15:0];
  a_illegal_irq: assert property (op_valid && bad |=> bus_error_irq && !io_req)
    else $error("illegal access not flagged");
  a_legal_io: assert property (op_valid && io_qualifier && !bad |=> io_req && !bus_error_irq)
    else $error("legal io access lost");
  a_data_space: assert property (op_valid && !io_qualifier |=> data_req && !io_req)
    else $error("data access misrouted");
  a_idle_quiet: assert property (!op_valid |=> !(io_req || data_req || bus_error_irq || aux_wb_en))
    else $error("output without operand");
  a_minus_wb: assert property (op_valid && op_kind == 4'h0 && !bad |=> aux_wb_en && aux_wb_value == {$past(ext_aux_pointer[22:16]), $past(dn)})
    else $error("write-back value wrong");
  a_coef_inc: assert property (op_valid && op_kind == 4'h4 && !coef_load |=> cp == {$past(cp[22:16]), $past(cp[15:0]) + 16'h1})
    else $error("coef increment wrong");
  a_coef_dec: assert property (op_valid && op_kind == 4'h5 && !coef_load |=> cp == {$past(cp[22:16]), $past(cp[15:0]) - 16'h1})
    else $error("coef decrement wrong");
  a_coef_hold: assert property (!coef_load && !(op_valid && op_kind inside {4'h4, 4'h5}) |=> $stable(cp))
    else $error("coef pointer moved");
  a_coef_addr: assert property (op_valid && op_kind inside {4'h3, 4'h4, 4'h5} |=> addr_out == {$past(cp[22:16]), $past(ca)})
    else $error("coef address wrong");
  cover property (op_valid && bad);
  cover property (op_valid && op_kind == 4'h4);
  cover property (op_valid && !io_qualifier);
endmodule
bind iosag_top iosag_monitor i_mon(.ref_clk, .reset_n, .op_valid, .io_qualifier, .delay_instr,
  .mac_with_delay_op, .coef_load, .aux_wb_en, .io_req, .data_req, .bus_error_irq, .op_kind,
  .index_reg_one, .coef_buffer_start, .status_reg_two, .ext_aux_pointer, .aux_wb_value,
  .ext_coef_pointer, .addr_out);

// >>> testbench/iosag_periph.sv
// Purpose: peripheral registers in I/O space
// Assumes: one access per io_req pulse
// Notes: keeps the last address and an access count
`timescale 1ns/1ps
module iosag_periph(input wire ref_clk, input wire io_req, input wire [22:0] addr_out);
  logic [22:0] last_addr = 23'h0;
  int          hits = 0;
  always @(posedge ref_clk) if (io_req) begin
    last_addr <= addr_out;
    hits <= hits + 1;
  end
endmodule

// >>> testbench/test_io_space_indirect_agen.sv
// Purpose: self-checking bench for the I/O address generator
// Assumes: answers one cycle after the operand edge
// Notes: table rows first, then back-to-back, wrap and reset cases
`timescale 1ns/1ps
module test_io_space_indirect_agen;
  typedef struct packed {
    logic [3:0] k; logic [2:0] n, c; logic q, d, m; logic [22:0] p; logic [15:0] x, s;
    logic [22:0] a; logic ir;
  } iosag_row_t;
  logic ref_clk = 0, reset_n = 0, op_valid = 0, io_qualifier = 0, delay_instr = 0;
  logic mac_with_delay_op = 0, coef_load = 0;
  logic [3:0] op_kind = 0;
  logic [2:0] aux_sel = 0, short_offset_const = 0;
  logic [22:0] ext_aux_pointer = 0, coef_load_value = 0;
  logic [15:0] index_reg_one = 0, aux_buffer_start = 16'h0100, coef_buffer_start = 16'h0040;
  logic [15:0] status_reg_two = 0;
  wire aux_wb_en, io_req, data_req, bus_error_irq;
  wire [22:0] aux_wb_value, ext_coef_pointer, addr_out;
  int failures = 0, comparisons = 0;
  iosag_row_t rows [14];
  iosag_top i_dut(.ref_clk, .reset_n, .op_valid, .op_kind, .aux_sel, .short_offset_const,
    .io_qualifier, .delay_instr, .mac_with_delay_op, .ext_aux_pointer, .index_reg_one,
    .aux_buffer_start, .coef_buffer_start, .status_reg_two, .coef_load, .coef_load_value,
    .aux_wb_en, .aux_wb_value, .ext_coef_pointer, .io_req, .data_req, .addr_out, .bus_error_irq);
  iosag_periph i_per(.ref_clk, .io_req, .addr_out);
  initial forever #5 ref_clk = ~ref_clk;
  task chk(input logic [22:0] got, input logic [22:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task summarize;
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task op(input iosag_row_t r);
    @(posedge ref_clk);
    {op_kind, aux_sel, short_offset_const, io_qualifier} <= {r.k, r.n, r.c, r.q};
    {delay_instr, mac_with_delay_op, ext_aux_pointer} <= {r.d, r.m, r.p};
    {index_reg_one, status_reg_two, op_valid} <= {r.x, r.s, 1'b1};
  endtask
  task load(input logic [22:0] v);
    @(posedge ref_clk) {coef_load, coef_load_value} <= {1'b1, v};
    @(posedge ref_clk) coef_load <= 1'b0;
  endtask
  task idle;
    @(posedge ref_clk) op_valid <= 1'b0;
    @(negedge ref_clk);
  endtask
  initial begin
    #100000 failures++;
    summarize;
  end
  initial begin
    rows = '{'{0,7,0,1,0,0,'h01ff80,3,0,'h01ff80,0}, '{1,7,0,1,0,0,'h00ff7d,3,0,'h00ff80,0},
      '{2,2,7,1,0,0,'h00fff0,0,4,'h0000f7,0}, '{2,3,4,1,0,0,'h00ff70,0,4,'h00ff74,0},
      '{3,0,0,1,0,0,0,0,'h100,'h050030,0}, '{4,0,0,1,0,0,0,0,0,'h05fff0,0},
      '{5,0,0,1,0,0,0,0,0,'h05fff1,0}, '{6,0,0,1,0,0,0,0,0,0,1}, '{7,0,0,1,0,0,0,0,0,0,1},
      '{8,0,0,1,0,0,0,0,0,0,1}, '{9,0,0,1,0,0,0,0,0,0,1}, '{3,0,0,1,1,0,0,0,0,0,1},
      '{3,0,0,1,0,1,0,0,0,0,1}, '{0,7,0,0,0,0,'h01ff80,3,0,'h01ff80,0}};
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    load(23'h05fff0);
    foreach (rows[i]) begin
      op(rows[i]);
      idle;
      chk(io_req, rows[i].q & !rows[i].ir);
      chk(data_req, !rows[i].q);
      chk(bus_error_irq, rows[i].ir);
      chk(aux_wb_en, rows[i].k == 0 && !rows[i].ir);
      if (rows[i].k == 0 && !rows[i].ir)
        chk(aux_wb_value, {rows[i].p[22:16], rows[i].p[15:0] - rows[i].x});
      if (!rows[i].ir) chk(addr_out, rows[i].a);
    end
    op(rows[5]);
    op(rows[5]);
    idle;
    chk(ext_coef_pointer, 23'h05fff2);
    chk(addr_out, 23'h05fff1);
    idle;
    chk(i_per.last_addr, 23'h05fff1);
    chk(i_per.hits[22:0], 23'd9);
    load(23'h12ffff);
    op(rows[5]);
    idle;
    chk(ext_coef_pointer, 23'h120000);
    op(rows[6]);
    idle;
    chk(addr_out, 23'h120000);
    chk(ext_coef_pointer, 23'h12ffff);
    @(posedge ref_clk) reset_n <= 1'b0;
    @(negedge ref_clk) chk(ext_coef_pointer, 23'h0);
    @(posedge ref_clk) reset_n <= 1'b1;
    @(negedge ref_clk);
    chk({19'h00000, io_req, data_req, bus_error_irq, aux_wb_en}, 23'h000000);
    chk(addr_out, 23'h000000);
    summarize;
  end
endmodule
